// ### hdl/t2b_pkg.sv
// Shared constants and types for the second timer and its serial-rate partner.
`default_nettype none
package t2b_pkg;

    // Bit positions inside timer_control_register.
    localparam int unsigned CTL_OVF  = 7;
    localparam int unsigned CTL_EXF  = 6;
    localparam int unsigned CTL_RXS  = 5;
    localparam int unsigned CTL_TXS  = 4;
    localparam int unsigned CTL_EXEN = 3;
    localparam int unsigned CTL_RUN  = 2;
    localparam int unsigned CTL_CNT  = 1;
    localparam int unsigned CTL_CAP  = 0;

    // Reset values and the full count.
    localparam logic [7:0]  CTL_RESET = 8'h00;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] REL_RESET = 16'h0000;
    localparam logic [15:0] CNT_FULL  = 16'hffff;

    // Prescaler periods in oscillator clocks.
    localparam logic [3:0] PRE_TMR_6  = 4'h6;
    localparam logic [3:0] PRE_TMR_12 = 4'hc;
    localparam logic [3:0] PRE_BAUD_6 = 4'h1;
    localparam logic [3:0] PRE_BAUD_12 = 4'h2;
    localparam logic [3:0] PRE_ONE    = 4'h1;
    localparam logic [3:0] PRE_ZERO   = 4'h0;

    // Serial bit rate is the selected overflow rate divided by sixteen.
    localparam logic [3:0] BIT_DIV_LAST = 4'hf;
    localparam logic [3:0] BIT_DIV_ZERO = 4'h0;

    // Setup values for timer use.
    localparam logic [7:0] SET_RELOAD_INT   = 8'h00;
    localparam logic [7:0] SET_RELOAD_EXT   = 8'h08;
    localparam logic [7:0] SET_CAPTURE_INT  = 8'h01;
    localparam logic [7:0] SET_CAPTURE_EXT  = 8'h09;
    localparam logic [7:0] SET_BAUD_BOTH_I  = 8'h34;
    localparam logic [7:0] SET_BAUD_BOTH_E  = 8'h36;
    localparam logic [7:0] SET_BAUD_RX_I    = 8'h24;
    localparam logic [7:0] SET_BAUD_RX_E    = 8'h26;
    localparam logic [7:0] SET_BAUD_TX_I    = 8'h14;
    localparam logic [7:0] SET_BAUD_TX_E    = 8'h16;

    // Setup values for counter use.
    localparam logic [7:0] SET_CNT_RELOAD_I = 8'h02;
    localparam logic [7:0] SET_CNT_RELOAD_E = 8'h0a;
    localparam logic [7:0] SET_CNT_CAPT_I   = 8'h03;
    localparam logic [7:0] SET_CNT_CAPT_E   = 8'h0b;

    // Divider factors for the internal-clock bit rate.
    localparam int unsigned FULL_SCALE = 65536;
    localparam int unsigned N_SIX      = 16;
    localparam int unsigned N_TWELVE   = 32;

    // Register selector on the access port.
    typedef enum logic [2:0] {
        SEL_CTRL,
        SEL_CNT_LO,
        SEL_CNT_HI,
        SEL_REL_LO,
        SEL_REL_HI
    } t2b_sel_e;

    // Reload value for a wanted bit rate with the internal clock.
    function automatic logic [15:0] t2b_reload_for(
        input int unsigned osc_hz,
        input int unsigned n,
        input int unsigned rate
    );
        int unsigned dv;
        dv = osc_hz / (n * rate);
        return 16'(FULL_SCALE - dv);
    endfunction

endpackage
`default_nettype wire

// ### hdl/t2b_link_if.sv
// Link between the timer and its serial-rate and register-access partner.
`timescale 1ns/10ps
`default_nettype none
interface t2b_link_if;
    logic               reg_wr;
    logic               reg_rd;
    t2b_pkg::t2b_sel_e  reg_sel;
    logic [7:0]         reg_wdata;
    logic [7:0]         reg_rdata;
    logic               reg_rvalid;
    logic               t1_ovf;
    logic               tx_tick;
    logic               rx_tick;

    modport dev (
        input  reg_wr,
        input  reg_rd,
        input  reg_sel,
        input  reg_wdata,
        input  t1_ovf,
        output reg_rdata,
        output reg_rvalid,
        output tx_tick,
        output rx_tick
    );

    modport host (
        output reg_wr,
        output reg_rd,
        output reg_sel,
        output reg_wdata,
        output t1_ovf,
        input  reg_rdata,
        input  reg_rvalid,
        input  tx_tick,
        input  rx_tick
    );
endinterface
`default_nettype wire

// ### hdl/t2b_timer.sv
// Sixteen-bit timer with reload, capture and baud generation modes.
//
// How it works
// - mode from select bits, capture bit, run
// - transmit rate from timer one or here
// - receive rate from timer one or here
// - transmit and receive selects act independently
// - baud mode overflow reloads from reload pair
// - bit rate is overflow rate over sixteen
// - timer mode counts every six or twelve
// - baud mode counts every one or two
// - internal bit rate osc over n times span
// - external count pin may clock the counter
// - software derives reload from wanted rate
// - baud overflow never sets overflow flag
// - baud trigger edge sets flag, no reload
// - software avoids counter access in baud
// - software reads but never writes reload
// - software stops timer before any access; guard still passes reload reads in baud
// - timer setup values for control register
// - counter setup values for control register
// - run bit set by separate write, except in baud setup values
// - trigger edge reloads or captures outside baud
// - select bits force reload, ignore capture
// - overflow flag set by hardware, software clears
`timescale 1ns/10ps
`default_nettype none
module t2b_timer (
    input  wire logic  mclk,
    input  wire logic  rst_n,
    input  wire logic  six_clock_mode,
    input  wire logic  count_input_pin,
    input  wire logic  ext_trigger_pin,
    t2b_link_if.dev    link,
    output logic       overflow_flag,
    output logic       ext_trigger_flag
);

    localparam int unsigned NPIN = 2;

    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_fall;
    logic [7:0]      ctl_q;
    logic [7:0]      ctl_d;
    logic [15:0]     cnt_q;
    logic [15:0]     cnt_d;
    logic [15:0]     rel_q;
    logic [15:0]     rel_d;
    logic [3:0]      pre_q;
    logic [3:0]      pre_d;
    logic [3:0]      period;
    logic [7:0]      rdata_q;
    logic [7:0]      rdata_d;
    logic            rvalid_q;
    logic            tx_tick_q;
    logic            tx_tick_d;
    logic            rx_tick_q;
    logic            rx_tick_d;
    logic            baud;
    logic            run;
    logic            pre_en;
    logic            tick;
    logic            ovf;
    logic            trig;
    logic [7:0]      lo_inc;
    logic [7:0]      hi_inc;

    // Pin 0 is the count input, pin 1 the trigger input.
    assign pin_raw = {ext_trigger_pin, count_input_pin};

    // Each pin passes three flops; a level counts once flops two and three agree.
    for (genvar i = 0; i < NPIN; i++) begin : g_pin
        logic s1_q;
        logic s2_q;
        logic s3_q;
        logic lvl_q;
        logic lvl_d;
        always_comb begin
            lvl_d = (s2_q == s3_q) ? s2_q : lvl_q;
        end
        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                s1_q  <= 1'b1;
                s2_q  <= 1'b1;
                s3_q  <= 1'b1;
                lvl_q <= 1'b1;
            end else begin
                s1_q  <= pin_raw[i];
                s2_q  <= s1_q;
                s3_q  <= s2_q;
                lvl_q <= lvl_d;
            end
        end
        assign pin_fall[i] = lvl_q & ~lvl_d;
    end

    // Mode decode and count enable.
    always_comb begin
        baud = ctl_q[t2b_pkg::CTL_RXS] | ctl_q[t2b_pkg::CTL_TXS];
        run  = ctl_q[t2b_pkg::CTL_RUN];
        if (baud) begin
            period = six_clock_mode ? t2b_pkg::PRE_BAUD_6
                                    : t2b_pkg::PRE_BAUD_12;
        end else begin
            period = six_clock_mode ? t2b_pkg::PRE_TMR_6
                                    : t2b_pkg::PRE_TMR_12;
        end
        pre_en = (pre_q >= period - t2b_pkg::PRE_ONE);
        if (!run || pre_en) begin
            pre_d = t2b_pkg::PRE_ZERO;
        end else begin
            pre_d = pre_q + t2b_pkg::PRE_ONE;
        end
        // The external pin replaces the prescaler when counting events.
        tick = run & (ctl_q[t2b_pkg::CTL_CNT] ? pin_fall[0] : pre_en);
        ovf  = tick & (cnt_q == t2b_pkg::CNT_FULL);
        trig = ctl_q[t2b_pkg::CTL_EXEN] & pin_fall[1];
    end

    // Counter, reload pair and control register next values.
    always_comb begin
        lo_inc = cnt_q[7:0] + 8'h01;
        hi_inc = cnt_q[15:8] + {7'h00, cnt_q[7:0] == 8'hff};
        cnt_d  = cnt_q;
        rel_d  = rel_q;
        ctl_d  = ctl_q;
        if (tick) begin
            if (ovf && (baud || !ctl_q[t2b_pkg::CTL_CAP])) begin
                cnt_d = rel_q;
            end else begin
                cnt_d = {hi_inc, lo_inc};
            end
        end
        // Trigger edges reload or capture only outside baud generation.
        if (trig && !baud) begin
            if (ctl_q[t2b_pkg::CTL_CAP]) begin
                rel_d = cnt_q;
            end else begin
                cnt_d = rel_q;
            end
        end
        // Software writes land here; a hardware set in the same cycle wins.
        if (link.reg_wr) begin
            unique case (link.reg_sel)
                t2b_pkg::SEL_CTRL:   ctl_d = link.reg_wdata;
                t2b_pkg::SEL_CNT_LO: cnt_d[7:0] = link.reg_wdata;
                t2b_pkg::SEL_CNT_HI: cnt_d[15:8] = link.reg_wdata;
                t2b_pkg::SEL_REL_LO: rel_d[7:0] = link.reg_wdata;
                t2b_pkg::SEL_REL_HI: rel_d[15:8] = link.reg_wdata;
                default: ;
            endcase
        end
        if (ovf && !baud) begin
            ctl_d[t2b_pkg::CTL_OVF] = 1'b1;
        end
        if (trig) begin
            ctl_d[t2b_pkg::CTL_EXF] = 1'b1;
        end
    end

    // Read data and rate ticks toward the serial side.
    always_comb begin
        unique case (link.reg_sel)
            t2b_pkg::SEL_CTRL:   rdata_d = ctl_q;
            t2b_pkg::SEL_CNT_LO: rdata_d = cnt_q[7:0];
            t2b_pkg::SEL_CNT_HI: rdata_d = cnt_q[15:8];
            t2b_pkg::SEL_REL_LO: rdata_d = rel_q[7:0];
            t2b_pkg::SEL_REL_HI: rdata_d = rel_q[15:8];
            default:             rdata_d = 8'h00;
        endcase
        if (!link.reg_rd) begin
            rdata_d = rdata_q;
        end
        // Each direction picks its source on its own select bit.
        tx_tick_d = ctl_q[t2b_pkg::CTL_TXS] ? ovf : link.t1_ovf;
        rx_tick_d = ctl_q[t2b_pkg::CTL_RXS] ? ovf : link.t1_ovf;
    end

    // State registers.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctl_q     <= t2b_pkg::CTL_RESET;
            cnt_q     <= t2b_pkg::CNT_RESET;
            rel_q     <= t2b_pkg::REL_RESET;
            pre_q     <= t2b_pkg::PRE_ZERO;
            rdata_q   <= 8'h00;
            rvalid_q  <= 1'b0;
            tx_tick_q <= 1'b0;
            rx_tick_q <= 1'b0;
        end else begin
            ctl_q     <= ctl_d;
            cnt_q     <= cnt_d;
            rel_q     <= rel_d;
            pre_q     <= pre_d;
            rdata_q   <= rdata_d;
            rvalid_q  <= link.reg_rd;
            tx_tick_q <= tx_tick_d;
            rx_tick_q <= rx_tick_d;
        end
    end

    // Outputs.
    assign link.reg_rdata  = rdata_q;
    assign link.reg_rvalid = rvalid_q;
    assign link.tx_tick    = tx_tick_q;
    assign link.rx_tick    = rx_tick_q;
    assign overflow_flag    = ctl_q[t2b_pkg::CTL_OVF];
    assign ext_trigger_flag = ctl_q[t2b_pkg::CTL_EXF];

endmodule // t2b_timer
`default_nettype wire

// ### hdl/t2b_host.sv
// Serial-rate partner: register access guard and divide-by-sixteen bit enables.
`timescale 1ns/10ps
`default_nettype none
module t2b_host (
    input  wire logic               mclk,
    input  wire logic               rst_n,
    input  wire logic               cmd_valid,
    input  wire logic               cmd_write,
    input  wire t2b_pkg::t2b_sel_e  cmd_sel,
    input  wire logic [7:0]         cmd_wdata,
    output logic                    cmd_ready,
    output logic                    cmd_refused,
    output logic                    rsp_valid,
    output logic [7:0]              rsp_data,
    input  wire logic               timer1_overflow,
    output logic                    tx_bit_en,
    output logic                    rx_bit_en,
    t2b_link_if.host                link
);

    localparam int unsigned NCH = 2;

    logic              take;
    logic              refuse;
    logic              is_cnt;
    logic              is_rel;
    logic              sh_run;
    logic              sh_baud;
    logic [7:0]        shadow_q;
    logic [7:0]        shadow_d;
    logic              pend_q;
    logic              pend_d;
    logic              wr_q;
    logic              rd_q;
    t2b_pkg::t2b_sel_e sel_q;
    logic [7:0]        wdata_q;
    logic              refused_q;
    logic              rsp_valid_q;
    logic [7:0]        rsp_data_q;
    logic [NCH-1:0]    ch_tick;
    logic [NCH-1:0]    ch_en;

    // Access guard driven by the last control value written.
    always_comb begin
        sh_run  = shadow_q[t2b_pkg::CTL_RUN];
        sh_baud = shadow_q[t2b_pkg::CTL_RXS] | shadow_q[t2b_pkg::CTL_TXS];
        is_cnt  = (cmd_sel == t2b_pkg::SEL_CNT_LO) ||
                  (cmd_sel == t2b_pkg::SEL_CNT_HI);
        is_rel  = (cmd_sel == t2b_pkg::SEL_REL_LO) ||
                  (cmd_sel == t2b_pkg::SEL_REL_HI);
        refuse  = sh_run & is_cnt;
        if (sh_run && is_rel && (cmd_write || !sh_baud)) begin
            refuse = 1'b1;
        end
        take     = cmd_valid & cmd_ready;
        shadow_d = shadow_q;
        if (take && cmd_write && cmd_sel == t2b_pkg::SEL_CTRL) begin
            shadow_d = cmd_wdata;
        end
        pend_d = pend_q;
        if (link.reg_rvalid) begin
            pend_d = 1'b0;
        end
        if (take && !cmd_write && !refuse) begin
            pend_d = 1'b1;
        end
    end

    // Access registers.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            shadow_q    <= t2b_pkg::CTL_RESET;
            pend_q      <= 1'b0;
            wr_q        <= 1'b0;
            rd_q        <= 1'b0;
            sel_q       <= t2b_pkg::SEL_CTRL;
            wdata_q     <= 8'h00;
            refused_q   <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_data_q  <= 8'h00;
        end else begin
            shadow_q    <= shadow_d;
            pend_q      <= pend_d;
            wr_q        <= take & cmd_write & ~refuse;
            rd_q        <= take & ~cmd_write & ~refuse;
            sel_q       <= take ? cmd_sel : sel_q;
            wdata_q     <= take ? cmd_wdata : wdata_q;
            refused_q   <= take & refuse;
            rsp_valid_q <= link.reg_rvalid;
            rsp_data_q  <= link.reg_rvalid ? link.reg_rdata : rsp_data_q;
        end
    end

    // One divide-by-sixteen per direction turns overflow ticks into bit enables.
    assign ch_tick = {link.rx_tick, link.tx_tick};
    for (genvar c = 0; c < NCH; c++) begin : g_div
        logic [3:0] div_q;
        logic [3:0] div_d;
        logic       en_q;
        logic       en_d;
        always_comb begin
            div_d = div_q;
            en_d  = 1'b0;
            if (ch_tick[c]) begin
                div_d = div_q + 4'h1;
                en_d  = (div_q == t2b_pkg::BIT_DIV_LAST);
            end
        end
        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                div_q <= t2b_pkg::BIT_DIV_ZERO;
                en_q  <= 1'b0;
            end else begin
                div_q <= div_d;
                en_q  <= en_d;
            end
        end
        assign ch_en[c] = en_q;
    end

    // Outputs.
    assign cmd_ready      = ~pend_q;
    assign cmd_refused    = refused_q;
    assign rsp_valid      = rsp_valid_q;
    assign rsp_data       = rsp_data_q;
    assign tx_bit_en      = ch_en[0];
    assign rx_bit_en      = ch_en[1];
    assign link.reg_wr    = wr_q;
    assign link.reg_rd    = rd_q;
    assign link.reg_sel   = sel_q;
    assign link.reg_wdata = wdata_q;
    assign link.t1_ovf    = timer1_overflow;

endmodule // t2b_host
`default_nettype wire

// ### verif/t2b_link_properties.sv
// Checker watching the link between the timer and its partner.
`timescale 1ns/10ps
`default_nettype none
module t2b_link_properties (
    input wire logic              mclk,
    input wire logic              rst_n,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire t2b_pkg::t2b_sel_e reg_sel,
    input wire logic [7:0]        reg_wdata,
    input wire logic [7:0]        reg_rdata,
    input wire logic              reg_rvalid,
    input wire logic              t1_ovf,
    input wire logic              tx_tick,
    input wire logic              rx_tick
);
    logic [5:0]        ctl_q, ctl_d;
    logic [15:0]       rel_q, rel_d;
    t2b_pkg::t2b_sel_e rs_q, rs_d;
    logic              qt_q, qt_d, sn_q, sn_d, rq_q, rq_d;
    logic [7:0]        rel_b;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // Shadow of software writes; the flag watch arms only when baud mode
    // is rewritten from baud mode, so no timer overflow can race it.
    always_comb begin
        ctl_d = ctl_q;
        rel_d = rel_q;
        qt_d  = qt_q;
        sn_d  = sn_q;
        rs_d  = reg_rd ? reg_sel : rs_q;
        rq_d  = reg_rd && reg_sel == t2b_pkg::SEL_CTRL && qt_q;
        if (reg_wr && reg_sel == t2b_pkg::SEL_CTRL) begin
            ctl_d = reg_wdata[5:0];
            qt_d  = !reg_wdata[7] && reg_wdata[5:4] != 2'h0 &&
                    ctl_q[5:4] != 2'h0;
            sn_d  = sn_q || reg_wdata[3];
        end
        if (reg_wr && reg_sel == t2b_pkg::SEL_REL_LO) rel_d[7:0] = reg_wdata;
        if (reg_wr && reg_sel == t2b_pkg::SEL_REL_HI) rel_d[15:8] = reg_wdata;
    end

    // Shadow registers, cleared by reset.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctl_q <= 6'h00;
            rel_q <= 16'h0000;
            rs_q  <= t2b_pkg::SEL_CTRL;
            qt_q  <= 1'b0;
            sn_q  <= 1'b0;
            rq_q  <= 1'b0;
        end else begin
            ctl_q <= ctl_d;
            rel_q <= rel_d;
            rs_q  <= rs_d;
            qt_q  <= qt_d;
            sn_q  <= sn_d;
            rq_q  <= rq_d;
        end
    end

    // Byte of the reload pair that the last read asked for.
    assign rel_b = (rs_q == t2b_pkg::SEL_REL_HI) ? rel_q[15:8] : rel_q[7:0];

    rd_answer_a: assert property (reg_rd |=> reg_rvalid)
        else $error("read got no answer");
    rd_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("answer without a read");
    ctl_echo_a: assert property (
        reg_rvalid && rs_q == t2b_pkg::SEL_CTRL |-> reg_rdata[5:0] == ctl_q)
        else $error("control bits read back wrong");
    rel_hold_a: assert property (
        reg_rvalid && !sn_q && (rs_q == t2b_pkg::SEL_REL_LO ||
        rs_q == t2b_pkg::SEL_REL_HI) |-> reg_rdata == rel_b)
        else $error("reload byte lost its written value");
    tx_source_a: assert property (
        !ctl_q[4] |=> tx_tick == $past(t1_ovf))
        else $error("transmit tick not from timer one");
    rx_source_a: assert property (
        !ctl_q[5] |=> rx_tick == $past(t1_ovf))
        else $error("receive tick not from timer one");
    same_source_a: assert property (
        ctl_q[4] == ctl_q[5] |=> tx_tick == rx_tick)
        else $error("ticks of one source differ");
    flag_quiet_a: assert property (
        reg_rvalid && rq_q |-> !reg_rdata[7])
        else $error("overflow flag set in baud mode");
    bad_sel_a: assert property (
        reg_rd && reg_sel > t2b_pkg::SEL_REL_HI |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");

    cover property (ctl_q[5:4] == 2'h3 && tx_tick);
    cover property (reg_rvalid && rq_q);
    cover property (!ctl_q[4] && tx_tick);
endmodule // t2b_link_properties
`default_nettype wire

// ### verif/t2b_bench.sv
// Bench joining the timer and its partner, driven through the command port.
`timescale 1ns/10ps
`default_nettype none
module t2b_bench;
    localparam int T1P  = 10;
    localparam int SPAN = t2b_pkg::FULL_SCALE - 16'hfff0;
    logic              mclk = 1'b0, rst_n = 1'b0, six = 1'b1, t1 = 1'b0;
    logic              cpin = 1'b1, tpin = 1'b1, cv = 1'b0, cw = 1'b0;
    logic              ready, refd, rv, txe, rxe, ovf, exf, got_ref;
    t2b_pkg::t2b_sel_e cs = t2b_pkg::SEL_CTRL;
    logic [7:0]        cd = 8'h00, rd, got;
    logic [3:0]        t1c = 4'h0;
    logic [7:0]        rows [4] = '{8'h04, t2b_pkg::SET_BAUD_TX_I,
        t2b_pkg::SET_BAUD_RX_I, t2b_pkg::SET_BAUD_BOTH_I | 8'h01};
    int                n_fail = 0, n_tests = 0, cyc = 0, j, k, a, b, pre;

    t2b_link_if link ();
    t2b_timer t2b_timer_inst (.mclk(mclk), .rst_n(rst_n), .six_clock_mode(six),
        .count_input_pin(cpin), .ext_trigger_pin(tpin), .link(link),
        .overflow_flag(ovf), .ext_trigger_flag(exf));
    t2b_host t2b_host_inst (.mclk(mclk), .rst_n(rst_n), .cmd_valid(cv),
        .cmd_write(cw), .cmd_sel(cs), .cmd_wdata(cd), .cmd_ready(ready),
        .cmd_refused(refd), .rsp_valid(rv), .rsp_data(rd),
        .timer1_overflow(t1), .tx_bit_en(txe), .rx_bit_en(rxe), .link(link));
    t2b_link_properties t2b_link_properties_inst (.mclk(mclk), .rst_n(rst_n),
        .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_sel(link.reg_sel),
        .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata),
        .reg_rvalid(link.reg_rvalid), .t1_ovf(link.t1_ovf),
        .tx_tick(link.tx_tick), .rx_tick(link.rx_tick));

    // Clock of 50 ns and a free cycle count used for time stamps.
    always #25 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;

    // Timer one stand-in: one overflow pulse every T1P cycles.
    always @(posedge mclk) begin
        t1c <= (!rst_n || t1c == 4'(T1P - 1)) ? 4'h0 : t1c + 4'h1;
        t1  <= rst_n && t1c == 4'(T1P - 1);
    end

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask

    // One command: held until taken, then answer or refusal collected.
    task automatic cmd(input logic w, input logic [2:0] s, input logic [7:0] d);
        int i;
        @(posedge mclk);
        cv <= 1'b1;
        cw <= w;
        cs <= t2b_pkg::t2b_sel_e'(s);
        cd <= d;
        i = 0;
        do begin
            @(negedge mclk);
            i++;
        end while (ready !== 1'b1 && i < 20);
        if (i >= 20) begin
            check(16'h0000, 16'h0001);
            complete_run();
        end
        @(posedge mclk);
        cv <= 1'b0;
        got_ref = 1'b0;
        got = 8'hxx;
        repeat (5) begin
            @(negedge mclk);
            if (refd === 1'b1) got_ref = 1'b1;
            if (rv === 1'b1) got = rd;
        end
    endtask

    task automatic wr(input logic [2:0] s, input logic [7:0] d);
        cmd(1'b1, s, d);
        check({15'h0000, got_ref}, 16'h0000);
    endtask

    task automatic rdx(input logic [2:0] s, input logic [7:0] e);
        cmd(1'b0, s, 8'h00);
        check({8'h00, got}, {8'h00, e});
    endtask

    task automatic refx(input logic w, input logic [2:0] s);
        cmd(w, s, 8'h00);
        check({15'h0000, got_ref}, 16'h0001);
    endtask

    // Falling edge on the trigger pin or the count pin, then idle high.
    task automatic fall(input logic trig);
        @(posedge mclk);
        if (trig) tpin <= 1'b0;
        else cpin <= 1'b0;
        repeat (6) @(posedge mclk);
        tpin <= 1'b1;
        cpin <= 1'b1;
        repeat (6) @(posedge mclk);
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: return link.tx_tick;
            1: return link.rx_tick;
            2: return txe;
            3: return rxe;
            default: return ovf;
        endcase
    endfunction

    // Waits for the next pulse of a watched signal and stamps its cycle.
    task automatic hi(input int s, output int t);
        int i;
        @(negedge mclk);
        for (i = 0; i < 3000 && pick(s) !== 1'b1; i++) @(negedge mclk);
        if (i == 3000) begin
            check(16'h0000, 16'h0001);
            complete_run();
        end
        t = cyc;
    endtask

    task automatic gap(input int s, input int e);
        hi(s, a);
        hi(s, b);
        check(16'(b - a), 16'(e));
    endtask

    initial begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        for (j = 0; j < 6; j++) rdx(3'(j), 8'h00);
        $display("reset values done");
        check(t2b_pkg::t2b_reload_for(20000000, 16, 78125), 16'hfff0);
        wr(3'h3, 8'hf0);
        wr(3'h4, 8'hff);
        wr(3'h1, 8'hf0);
        wr(3'h2, 8'hff);
        rdx(3'h3, 8'hf0);
        rdx(3'h4, 8'hff);
        wr(3'h0, t2b_pkg::SET_RELOAD_INT);
        for (j = 1; j >= 0; j--) begin
            @(posedge mclk) six <= j[0];
            wr(3'h0, 8'h04);
            hi(4, a);
            wr(3'h0, 8'h04);
            hi(4, b);
            check(16'(b - a), 16'(16 * (j ? 6 : 12)));
        end
        $display("timer mode done");
        for (j = 1; j >= 0; j--) begin
            @(posedge mclk) six <= j[0];
            pre = j ? 1 : 2;
            for (k = 0; k < 4; k++) begin
                wr(3'h0, rows[k]);
                gap(0, rows[k][4] ? SPAN * pre : T1P);
                gap(1, rows[k][5] ? SPAN * pre : T1P);
            end
            wr(3'h0, rows[3]);
            gap(2, (j ? t2b_pkg::N_SIX : t2b_pkg::N_TWELVE) * SPAN);
            gap(3, 16 * SPAN * pre);
            check({15'h0000, ovf}, 16'h0000);
            rdx(3'h0, rows[3]);
        end
        $display("baud rates done");
        refx(1'b1, 3'h1);
        refx(1'b0, 3'h2);
        refx(1'b1, 3'h3);
        rdx(3'h3, 8'hf0);
        wr(3'h0, 8'h04);
        refx(1'b0, 3'h3);
        wr(3'h0, 8'h00);
        $display("access guard done");
        wr(3'h1, 8'h11);
        wr(3'h2, 8'h00);
        wr(3'h3, 8'h66);
        wr(3'h4, 8'h55);
        wr(3'h0, t2b_pkg::SET_RELOAD_EXT);
        fall(1'b1);
        rdx(3'h1, 8'h66);
        rdx(3'h2, 8'h55);
        check({15'h0000, exf}, 16'h0001);
        wr(3'h1, 8'h33);
        wr(3'h2, 8'h22);
        wr(3'h0, t2b_pkg::SET_CAPTURE_EXT);
        fall(1'b1);
        rdx(3'h3, 8'h33);
        rdx(3'h4, 8'h22);
        // With internal control a trigger edge must neither capture nor flag.
        wr(3'h1, 8'h44);
        wr(3'h0, t2b_pkg::SET_CAPTURE_INT);
        fall(1'b1);
        rdx(3'h3, 8'h33);
        check({15'h0000, exf}, 16'h0000);
        wr(3'h0, t2b_pkg::SET_BAUD_BOTH_I | 8'h08);
        fall(1'b1);
        rdx(3'h0, 8'h7c);
        rdx(3'h3, 8'h33);
        wr(3'h0, 8'h00);
        $display("trigger done");
        wr(3'h1, 8'hff);
        wr(3'h2, 8'h00);
        wr(3'h0, t2b_pkg::SET_CNT_RELOAD_I);
        wr(3'h0, t2b_pkg::SET_CNT_RELOAD_I | 8'h04);
        for (j = 0; j < 5; j++) fall(1'b0);
        wr(3'h0, 8'h00);
        rdx(3'h1, 8'h04);
        rdx(3'h2, 8'h01);
        $display("count pin done");
        complete_run();
    end
endmodule // t2b_bench
`default_nettype wire
